// File: common/exec_slice_pkg.sv
// Shared types and constants for the return, rotate, sleep and subtract execution slice
package exec_slice_pkg;
   localparam int          DATA_W     = 8;
   localparam int          MSB        = 7;
   localparam int          NIB_MSB    = 3;
   localparam int          PC_W_DEF   = 12;
   localparam logic [7:0]  ACC_RST    = 8'h00;
   localparam logic [7:0]  ZERO_BYTE  = 8'h00;
   localparam logic [7:0]  ADDR_RST   = 8'h00;
   localparam logic        DEST_ACC   = 1'b0;
   localparam logic        DEST_FILE  = 1'b1;

   // Operation codes of this slice; the real opcode bit patterns are decoded upstream
   typedef enum logic [2:0] {
      IRQ_RETURN_OP         = 3'b000,
      RETURN_LITERAL_OP     = 3'b001,
      SUB_RETURN_OP         = 3'b010,
      ROTATE_LEFT_CARRY_OP  = 3'b011,
      ROTATE_RIGHT_CARRY_OP = 3'b100,
      SLEEP_OP              = 3'b101,
      LITERAL_MINUS_ACC_OP  = 3'b110,
      NO_OP                 = 3'b111
   } op_type;

   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_RET_TAIL = 2'b01,
      ST_ASLEEP   = 2'b10
   } state_type;

   typedef struct packed {
      op_type      op;
      logic [7:0]  literal;
      logic [7:0]  fileAddr;
      logic        destSel;
   } op_req_type;

   typedef struct packed {
      logic carry;
      logic digitCarry;
      logic zero;
      logic powerDown;
   } status_type;

   localparam status_type STATUS_RST = 4'h0;
endpackage

// File: design/return_rotate_sleep_sub_exec.sv
// Execution slice: returns, rotates through carry, sleep and literal-minus-accumulator
// Contract
// RULE1: Interrupt return loads PC from stack top, pops, sets irq enable, two cycles.
// RULE2: Literal return writes literal to accumulator, loads PC, pops, keeps flags, two cycles.
// RULE3: Plain return loads PC from stack top then pops, flags untouched, two cycles.
// RULE4: Rotate left: bits move up, old carry to bit 0, bit 7 to carry, zero updated.
// RULE5: Rotate right: bits move down, old carry to bit 7, bit out goes to carry.
// RULE6: Rotate destination 0 writes accumulator, 1 writes the addressed file register.
// RULE7: Sleep stops the oscillator, sets power-down flag, one cycle, external wake resumes.
// RULE8: Literal minus accumulator goes to accumulator, updating carry, digit carry, zero.
// RULE9: Carry is inverted borrow; zero set only for a zero difference.
// RULE10: Software clears pending interrupt flags before sleeping to avoid instant wake.
// RULE11: Program places a no-operation directly after every sleep instruction.
// RULE12: Rotate and literal subtract complete in a single cycle.
// RULE13: Digit carry set when no borrow passes from bit 4 into bit 3.
`timescale 1ns/10ps
module return_rotate_sleep_sub_exec #(
   parameter int PC_W = exec_slice_pkg::PC_W_DEF
) (
   input  wire logic                      clk_sys,
   input  wire logic                      arst_n,
   input  wire logic                      opValid,
   input  wire exec_slice_pkg::op_req_type opReq,
   output logic                           opReady,
   input  wire logic [7:0]                fileRdData,
   input  wire logic [PC_W-1:0]           stackTop,
   input  wire logic                      wakeReq,
   output logic                           pcLoad,
   output logic [PC_W-1:0]                pcValue,
   output logic                           stackPop,
   output logic                           fileWrEn,
   output logic [7:0]                     fileWrAddr,
   output logic [7:0]                     fileWrData,
   output logic [7:0]                     accValue,
   output exec_slice_pkg::status_type     status,
   output logic                           globalIrqEnable,
   output logic                           oscRun,
   output logic                           opDone
);
   exec_slice_pkg::state_type  state_ff, nxt_state;
   exec_slice_pkg::op_req_type pend_ff;
   exec_slice_pkg::status_type status_ff, nxt_status;
   logic [7:0]      acc_ff, nxt_acc;
   logic [PC_W-1:0] pcValue_ff;
   logic            pcLoad_ff, stackPop_ff, fileWrEn_ff, gie_ff, oscRun_ff, opDone_ff;
   logic [7:0]      fileWrAddr_ff, fileWrData_ff;
   logic            wakeS1_ff, wakeS2_ff, wakeS3_ff, wakeLevel_ff;

   // Request decode
   wire logic accept   = opValid & opReady;
   wire logic isIrqRet = opReq.op == exec_slice_pkg::IRQ_RETURN_OP;
   wire logic isLitRet = opReq.op == exec_slice_pkg::RETURN_LITERAL_OP;
   wire logic isRet    = isIrqRet | isLitRet | (opReq.op == exec_slice_pkg::SUB_RETURN_OP);
   wire logic isRotL   = opReq.op == exec_slice_pkg::ROTATE_LEFT_CARRY_OP;
   wire logic isRotR   = opReq.op == exec_slice_pkg::ROTATE_RIGHT_CARRY_OP;
   wire logic isRot    = isRotL | isRotR;
   wire logic isSleep  = opReq.op == exec_slice_pkg::SLEEP_OP;
   wire logic isSub    = opReq.op == exec_slice_pkg::LITERAL_MINUS_ACC_OP;
   wire logic retTail  = state_ff == exec_slice_pkg::ST_RET_TAIL;
   wire logic asleep   = state_ff == exec_slice_pkg::ST_ASLEEP;
   wire logic doRot    = accept & isRot;
   wire logic doSub    = accept & isSub;
   wire logic rotToAcc = doRot & (opReq.destSel == exec_slice_pkg::DEST_ACC);  // [RULE6]
   wire logic rotToFile = doRot & (opReq.destSel == exec_slice_pkg::DEST_FILE); // [RULE6]

   // Rotate datapath; carry is the ninth bit of the ring
   wire logic [7:0] rotLeft  = {fileRdData[exec_slice_pkg::MSB-1:0], status_ff.carry}; // [RULE4]
   wire logic [7:0] rotRight = {status_ff.carry, fileRdData[exec_slice_pkg::MSB:1]};   // [RULE5]
   wire logic [7:0] rotRes   = isRotL ? rotLeft : rotRight;
   wire logic       rotCarry = isRotL ? fileRdData[exec_slice_pkg::MSB]  // [RULE4]
                                      : fileRdData[0];                   // [RULE5]

   // Subtract datapath; carry and digit carry read as inverted borrows
   wire logic [7:0] subDiff  = 8'(opReq.literal - acc_ff);                 // [RULE8]
   wire logic       subCarry = opReq.literal >= acc_ff;                     // [RULE9]
   wire logic       subDc    = opReq.literal[exec_slice_pkg::NIB_MSB:0]
                               >= acc_ff[exec_slice_pkg::NIB_MSB:0];        // [RULE13]
   wire logic [7:0] selRes   = doSub ? subDiff : rotRes;

   // Synchronised wake level counts only once the last two stages agree
   wire logic wakeAgree = wakeS2_ff == wakeS3_ff;
   wire logic wakeNow   = asleep & wakeLevel_ff;                            // [RULE7]

   // Sequencer: returns need a tail cycle, sleep parks until woken
   always_comb begin
      case (state_ff)
         exec_slice_pkg::ST_IDLE: begin
            if (accept && isRet) begin
               nxt_state = exec_slice_pkg::ST_RET_TAIL;              // [RULE1] [RULE2] [RULE3]
            end else if (accept && isSleep) begin
               nxt_state = exec_slice_pkg::ST_ASLEEP;                      // [RULE7]
            end else begin
               nxt_state = exec_slice_pkg::ST_IDLE;                        // [RULE12]
            end
         end
         exec_slice_pkg::ST_RET_TAIL: nxt_state = exec_slice_pkg::ST_IDLE;
         exec_slice_pkg::ST_ASLEEP: begin
            // A wake level already high when sleeping ends the nap at once
            nxt_state = wakeNow ? exec_slice_pkg::ST_IDLE                  // [RULE10]
                                : exec_slice_pkg::ST_ASLEEP;
         end
         default: nxt_state = exec_slice_pkg::ST_IDLE;
      endcase
   end

   // Accumulator source: literal on literal return, rotate or subtract result
   assign nxt_acc = (retTail && pend_ff.op == exec_slice_pkg::RETURN_LITERAL_OP)
                    ? pend_ff.literal                                      // [RULE2]
                    : (rotToAcc | doSub) ? selRes : acc_ff;                // [RULE6] [RULE8]

   // Flags: returns leave every flag alone, so only rotate, subtract and sleep touch them
   assign nxt_status.carry      = doRot ? rotCarry                         // [RULE4] [RULE5]
                                : doSub ? subCarry : status_ff.carry;      // [RULE9]
   assign nxt_status.digitCarry = doSub ? subDc : status_ff.digitCarry;    // [RULE13]
   assign nxt_status.zero       = (doRot | doSub) ? (selRes == exec_slice_pkg::ZERO_BYTE)
                                : status_ff.zero;                          // [RULE9]
   assign nxt_status.powerDown  = (accept & isSleep) | status_ff.powerDown; // [RULE7]

   // Pin synchroniser
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wakeS1_ff    <= 1'b0;
         wakeS2_ff    <= 1'b0;
         wakeS3_ff    <= 1'b0;
         wakeLevel_ff <= 1'b0;
      end else begin
         wakeS1_ff    <= wakeReq;
         wakeS2_ff    <= wakeS1_ff;
         wakeS3_ff    <= wakeS2_ff;
         wakeLevel_ff <= wakeAgree ? wakeS3_ff : wakeLevel_ff;
      end
   end

   // Core state, accumulator and flags
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_ff  <= exec_slice_pkg::ST_IDLE;
         pend_ff   <= '0;
         acc_ff    <= exec_slice_pkg::ACC_RST;
         status_ff <= exec_slice_pkg::STATUS_RST;
      end else begin
         state_ff  <= nxt_state;
         pend_ff   <= accept ? opReq : pend_ff;
         acc_ff    <= nxt_acc;
         status_ff <= nxt_status;
      end
   end

   // Return tail: PC is taken from the stack top in the same cycle the pop is issued
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pcLoad_ff   <= 1'b0;
         stackPop_ff <= 1'b0;
         pcValue_ff  <= '0;
         gie_ff      <= 1'b0;
      end else begin
         pcLoad_ff   <= retTail;                                           // [RULE3]
         stackPop_ff <= retTail;                                           // [RULE1] [RULE3]
         pcValue_ff  <= retTail ? stackTop : pcValue_ff;                   // [RULE2]
         gie_ff      <= gie_ff                                             // [RULE1]
                        | (retTail && pend_ff.op == exec_slice_pkg::IRQ_RETURN_OP);
      end
   end

   // File write-back, oscillator gate and completion pulse
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fileWrEn_ff   <= 1'b0;
         fileWrAddr_ff <= exec_slice_pkg::ADDR_RST;
         fileWrData_ff <= exec_slice_pkg::ZERO_BYTE;
         oscRun_ff     <= 1'b1;
         opDone_ff     <= 1'b0;
      end else begin
         fileWrEn_ff   <= rotToFile;                                       // [RULE6]
         fileWrAddr_ff <= rotToFile ? opReq.fileAddr : fileWrAddr_ff;
         fileWrData_ff <= rotToFile ? rotRes : fileWrData_ff;
         oscRun_ff     <= (accept & isSleep) ? 1'b0 : (wakeNow | oscRun_ff); // [RULE7]
         opDone_ff     <= (accept & ~isRet) | retTail;                     // [RULE12]
      end
   end

   assign opReady         = state_ff == exec_slice_pkg::ST_IDLE;
   assign pcLoad          = pcLoad_ff;
   assign pcValue         = pcValue_ff;
   assign stackPop        = stackPop_ff;
   assign fileWrEn        = fileWrEn_ff;
   assign fileWrAddr      = fileWrAddr_ff;
   assign fileWrData      = fileWrData_ff;
   assign accValue        = acc_ff;
   assign status          = status_ff;
   assign globalIrqEnable = gie_ff;
   assign oscRun          = oscRun_ff;
   assign opDone          = opDone_ff;

   // Helpers that remember the operands seen in the previous cycle
   logic [7:0] prevOperand_ff, prevLit_ff, prevAcc_ff;
   logic       prevCarry_ff;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         prevOperand_ff <= exec_slice_pkg::ZERO_BYTE;
         prevLit_ff     <= exec_slice_pkg::ZERO_BYTE;
         prevAcc_ff     <= exec_slice_pkg::ZERO_BYTE;
         prevCarry_ff   <= 1'b0;
      end else begin
         prevOperand_ff <= fileRdData;
         prevLit_ff     <= opReq.literal;
         prevAcc_ff     <= acc_ff;
         prevCarry_ff   <= status_ff.carry;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   irq_return_a: assert property (accept && isIrqRet |=> !opReady ##1 // [RULE1]
      (pcLoad && stackPop && globalIrqEnable && status == $past(status, 2)))
      else $error("interrupt return sequence wrong");
   lit_return_a: assert property (accept && isLitRet |-> ##2 // [RULE2]
      (accValue == $past(opReq.literal, 2) && pcLoad && opDone))
      else $error("literal return did not load accumulator");
   plain_return_a: assert property (accept && isRet |=> retTail ##1 // [RULE3]
      (pcValue == $past(stackTop) && stackPop && status == $past(status, 2)))
      else $error("return did not take stack top");
   rotate_left_a: assert property (rotToAcc && isRotL |=> // [RULE4]
      (accValue == {prevOperand_ff[6:0], prevCarry_ff} && status.carry == prevOperand_ff[7]
       && status.zero == (accValue == exec_slice_pkg::ZERO_BYTE)))
      else $error("rotate left result wrong");
   rotate_right_a: assert property (rotToFile && isRotR |=> // [RULE5]
      (fileWrData == {prevCarry_ff, prevOperand_ff[7:1]} && status.carry == prevOperand_ff[0]))
      else $error("rotate right result wrong");
   rotate_dest_a: assert property (doRot |=> // [RULE6]
      (fileWrEn == $past(opReq.destSel) && (!fileWrEn || fileWrAddr == $past(opReq.fileAddr))))
      else $error("rotate destination wrong");
   sleep_entry_a: assert property (accept && isSleep |=> // [RULE7]
      (!oscRun && status.powerDown && !opReady && opDone))
      else $error("sleep did not stop oscillator");
   sleep_wake_a: assert property (asleep && wakeLevel_ff |=> oscRun && opReady) // [RULE7]
      else $error("wake did not resume core");
   sub_result_a: assert property (doSub |=> // [RULE8]
      accValue == 8'(prevLit_ff - prevAcc_ff))
      else $error("subtract result wrong");
   sub_flags_a: assert property (doSub |=> // [RULE9]
      (status.carry == (prevLit_ff >= prevAcc_ff)
       && status.zero == (prevLit_ff == prevAcc_ff)))
      else $error("subtract carry or zero wrong");
   single_cycle_a: assert property (accept && (isRot || isSub) |=> opReady && opDone) // [RULE12]
      else $error("single cycle op stalled");
   digit_carry_a: assert property (doSub |=> // [RULE13]
      status.digitCarry == (prevLit_ff[3:0] >= prevAcc_ff[3:0]))
      else $error("digit carry wrong");

   sleep_wake_c: cover property (accept && isSleep ##[1:20] (asleep && wakeLevel_ff));
   sub_borrow_c: cover property (doSub && !subCarry);
   irq_ret_c:    cover property (accept && isIrqRet ##2 globalIrqEnable);
endmodule

// File: test/exec_partner_model.sv
// Behavioural file registers and return stack facing the execution slice
`timescale 1ns/10ps
module exec_partner_model #(
   parameter int PC_W = 12
) (
   input  wire logic            clk_sys,
   input  wire logic [7:0]      rdAddr,
   input  wire logic            fileWrEn,
   input  wire logic [7:0]      fileWrAddr,
   input  wire logic [7:0]      fileWrData,
   input  wire logic            stackPop,
   output logic [7:0]           fileRdData,
   output logic [PC_W-1:0]      stackTop
);
   logic [7:0]      fRegs [256];
   logic [PC_W-1:0] stk   [16];
   int              sp = 15;
   // Reads are combinational because the core samples file data at acceptance and the stack top in the tail cycle
   assign fileRdData = fRegs[rdAddr];
   assign stackTop   = stk[sp[3:0]];
   // Write back and pop only on the core's one-cycle pulses
   always @(posedge clk_sys) begin
      if (fileWrEn) begin
         fRegs[fileWrAddr] <= fileWrData;
      end
      if (stackPop) begin
         sp <= sp - 1;
      end
   end
endmodule

// File: test/return_rotate_sleep_sub_exec_tb_top.sv
// Self-checking bench for the return, rotate, sleep and subtract slice
`timescale 1ns/10ps
module return_rotate_sleep_sub_exec_tb_top;
   localparam int PC_W = 12;
   logic clk_sys, arst_n, opValid, wakeReq, opReady, pcLoad, stackPop;
   logic fileWrEn, globalIrqEnable, oscRun, opDone, global_irq_enable;
   logic [7:0] fileRdData, fileWrAddr, fileWrData, accValue, w, k;
   logic [PC_W-1:0] stackTop, pcValue;
   exec_slice_pkg::op_req_type opReq;
   exec_slice_pkg::status_type status, st;
   logic [7:0] fm [256];
   logic [PC_W-1:0] sm [16];
   int sp, mismatches, n_checks;

   return_rotate_sleep_sub_exec #(.PC_W(PC_W)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
      .opValid(opValid), .opReq(opReq), .opReady(opReady), .fileRdData(fileRdData),
      .stackTop(stackTop), .wakeReq(wakeReq), .pcLoad(pcLoad), .pcValue(pcValue),
      .stackPop(stackPop), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
      .fileWrData(fileWrData), .accValue(accValue), .status(status),
      .globalIrqEnable(globalIrqEnable), .oscRun(oscRun), .opDone(opDone));
   exec_partner_model #(.PC_W(PC_W)) mem_u (.clk_sys(clk_sys), .rdAddr(opReq.fileAddr),
      .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
      .stackPop(stackPop), .fileRdData(fileRdData), .stackTop(stackTop));

   // Free-running system clock
   always #4 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic print_verdict;
      if (mismatches == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One request, released at the edge that takes it; returns 1 ns after that edge
   task automatic runOp(input exec_slice_pkg::op_type o, input logic [7:0] lit,
                        input logic [7:0] a, input logic d);
      @(posedge clk_sys);
      opValid <= 1'b1;
      opReq   <= '{o, lit, a, d};
      // Hold the request until an edge that samples the core ready
      @(posedge clk_sys);
      while (opReady !== 1'b1) @(posedge clk_sys);
      opValid <= 1'b0;
      #1;
   endtask

   task automatic chkState;
      chk(opDone, 1'b1, "done");
      chk(accValue, w, "acc");
      chk(status, st, "flags");
      chk(globalIrqEnable, global_irq_enable, "irq enable");
   endtask

   task automatic doSub(input logic [7:0] lit);
      runOp(exec_slice_pkg::LITERAL_MINUS_ACC_OP, lit, 8'h00, 1'b0);
      st.carry = (lit >= w);
      st.digitCarry = (lit[3:0] >= w[3:0]);
      w = lit - w;
      st.zero = (w == 8'h00);
      chkState();
   endtask

   // Expected rotate result: old carry enters where the operand bits move away from
   function automatic logic [7:0] rotExp(input logic left, input logic [7:0] f, input logic c);
      return left ? {f[6:0], c} : {c, f[7:1]};
   endfunction

   task automatic doRot(input logic left, input logic [7:0] a, input logic d);
      logic [7:0] f;
      logic [7:0] r;
      f = fm[a];
      runOp(left ? exec_slice_pkg::ROTATE_LEFT_CARRY_OP : exec_slice_pkg::ROTATE_RIGHT_CARRY_OP,
            8'h00, a, d);
      r = rotExp(left, f, st.carry);
      st.carry = left ? f[7] : f[0];
      st.zero = (r == 8'h00);
      if (d) fm[a] = r;
      else w = r;
      chkState();
      chk(fileWrEn, d, "rot write");
      if (d) chk({fileWrAddr, fileWrData}, {a, r}, "rot dest");
   endtask

   // One return of kind i; flags and accumulator may be non-zero, so keeping them is tested
   task automatic doRet(input int i);
      k = 8'($urandom);
      runOp(exec_slice_pkg::op_type'(i), k, 8'h00, 1'b0);
      chk({opReady, opDone}, 2'b00, "ret tail");
      @(posedge clk_sys);
      #1;
      if (i == 1) w = k;
      if (i == 0) global_irq_enable = 1'b1;
      chk({pcLoad, stackPop}, 2'b11, "ret pulses");
      chk(pcValue, sm[sp[3:0]], "pc");
      sp--;
      chkState();
   endtask

   // Watchdog sized well beyond the roughly 500 cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      print_verdict();
   end

   initial begin
      {clk_sys, arst_n, opValid, wakeReq, global_irq_enable} = '0;
      opReq = '0;
      st = '0;
      w = 8'h00;
      sp = 15;
      k = 8'($urandom(32'h4666_6229));
      for (int i = 0; i < 256; i++) begin
         fm[i] = 8'($urandom);
         mem_u.fRegs[i] = fm[i];
      end
      for (int i = 0; i < 16; i++) begin
         sm[i] = PC_W'($urandom);
         mem_u.stk[i] = sm[i];
      end
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      #1;
      chk({opReady, oscRun, accValue, status}, {2'b11, 12'h000}, "reset");
      // The three returns, each with its one-cycle tail
      for (int i = 0; i < 3; i++) begin
         doRet(i);
      end
      // Literal-minus corners: smaller, equal, larger accumulator, then a nibble borrow
      for (int i = 1; i < 4; i++) begin
         doSub(8'(i) + w);
         doSub(8'h02);
      end
      doSub(8'h01 + w);
      doSub(8'h10);
      doRot(1'b1, 8'hFF, 1'b1);
      doRot(1'b0, 8'h00, 1'b0);
      // Random mix of rotates, returns and subtracts
      for (int i = 0; i < 200; i++) begin
         case ($urandom_range(3))
            0: doRot(1'b1, 8'($urandom), 1'($urandom));
            1: doRot(1'b0, 8'($urandom), 1'($urandom));
            2: doRet(int'($urandom_range(2)));
            default: doSub(8'($urandom));
         endcase
      end
      // Sleep with wake held low beforehand, so it cannot wake at once
      runOp(exec_slice_pkg::SLEEP_OP, 8'h00, 8'h00, 1'b0);
      st.powerDown = 1'b1;
      chkState();
      chk({oscRun, opReady}, 2'b00, "asleep");
      repeat (6) @(posedge clk_sys);
      #1;
      chk({oscRun, opReady}, 2'b00, "still asleep");
      @(posedge clk_sys);
      wakeReq <= 1'b1;
      for (int j = 0; j < 12 && opReady !== 1'b1; j++) @(posedge clk_sys);
      #1;
      chk({oscRun, opReady}, 2'b11, "woken");
      @(posedge clk_sys);
      wakeReq <= 1'b0;
      runOp(exec_slice_pkg::NO_OP, 8'h5A, 8'h00, 1'b0);
      chkState();
      print_verdict();
   end
endmodule
